// file: hw/arl_alarm_relay.sv
// Purpose: Two-input alarm supervision with two relay drivers
// Assumes: Readings arrive on the hclk domain with a valid strobe
// Notes:   Registers over AHB-Lite, zero wait states
//
// Overview of operation
// - Enabled input: reading above high sets high
// - Enabled input: reading below low sets low
// - Reset: alarm off, low 0 K, high 1000 K
// - Indicator steady when enabled alarm is visible
// - Indicator flashes while visible alarm active
// - Displayed input alternates status and reading while its alarm is active
// - Audible active alarm drives the beeper
// - Reset: visible and audible both on
// - Latching holds alarm until alarm reset
// - Non-latching alarm tracks reading with hysteresis
// - Alarms release one dead band past setpoint
// - Reset: latching off, dead band 1 K
// - Two relays, each assignable to any input
// - Off mode keeps coil de-energized
// - On mode keeps coil energized
// - Alarm mode low follows low alarm
// - Alarm mode high follows high alarm
// - Alarm mode both follows either alarm
// - Reset: relays off, input A, both
module arl_alarm_relay
    import arl_pkg::*;
#(
    parameter int unsigned RD_W      = 32,
    parameter int unsigned FLASH_LEN = FLASH_CYC
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic [RD_W-1:0]   reading_a,
    input  wire logic [RD_W-1:0]   reading_b,
    input  wire logic [1:0]        reading_valid,
    input  wire logic              display_sel,
    output logic      [1:0]        relay_coil,
    output logic                   alarm_led,
    output logic                   beeper,
    output logic                   disp_show_status
);

    initial begin
        if (RD_W < 8 || RD_W > 32)
            $error("RD_W out of range");
        if (FLASH_LEN < 2)
            $error("FLASH_LEN too small");
    end

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    logic        wr_pend_q;
    logic [7:0]  addr_q;
    logic        acc;

    assign acc = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= acc && hwrite;
            if (acc)
                addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers, one set per input
    // ----------------------------------------------------------------
    logic [3:0]       ctrl_q   [2];
    logic [RD_W-1:0]  low_q    [2];
    logic [RD_W-1:0]  high_q   [2];
    logic [RD_W-1:0]  dband_q  [2];
    logic [RD_W-1:0]  rd_q     [2];
    logic [1:0]       hi_q;
    logic [1:0]       lo_q;
    logic             areset;
    logic [RD_W-1:0]  rd_in    [2];

    assign rd_in[0] = reading_a;
    assign rd_in[1] = reading_b;
    // Confirmed alarm reset from the operator path
    assign areset = wr_pend_q && addr_q == OFF_ARESET && hwdata[0];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_in
            localparam logic [7:0] BASE = 8'(gi * CH_STRIDE);
            logic     en, latch;
            logic     above, below, hi_rel, lo_rel;
            logic     hi_d, lo_d;

            assign en    = ctrl_q[gi][CTL_EN];
            assign latch = ctrl_q[gi][CTL_LATCH];

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    ctrl_q[gi]  <= RST_CTRL;
                    low_q[gi]   <= RD_W'(RST_LOW);
                    high_q[gi]  <= RD_W'(RST_HIGH);
                    dband_q[gi] <= RD_W'(RST_DBAND);
                end else if (wr_pend_q) begin
                    if (addr_q == BASE + OFF_CTRL_A)
                        ctrl_q[gi] <= hwdata[3:0];
                    if (addr_q == BASE + OFF_LOW_A)
                        low_q[gi] <= hwdata[RD_W-1:0];
                    if (addr_q == BASE + OFF_HIGH_A)
                        high_q[gi] <= hwdata[RD_W-1:0];
                    if (addr_q == BASE + OFF_DBAND_A)
                        dband_q[gi] <= hwdata[RD_W-1:0];
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn)
                    rd_q[gi] <= '0;
                else if (reading_valid[gi])
                    rd_q[gi] <= rd_in[gi];
            end

            // Compare against the incoming reading so the flag and the
            // relays move on the strobe edge itself
            assign above  = rd_in[gi] > high_q[gi];
            assign below  = rd_in[gi] < low_q[gi];
            // Release thresholds; widened one bit so no wrap at range ends
            assign hi_rel = ({1'b0, rd_in[gi]} + {1'b0, dband_q[gi]})
                            <= {1'b0, high_q[gi]};
            assign lo_rel = {1'b0, rd_in[gi]}
                            >= ({1'b0, low_q[gi]} + {1'b0, dband_q[gi]});

            always_comb begin
                hi_d = hi_q[gi];
                lo_d = lo_q[gi];
                if (reading_valid[gi]) begin
                    if (above)
                        hi_d = 1'b1;
                    else if (!latch && hi_rel)
                        hi_d = 1'b0;
                    if (below)
                        lo_d = 1'b1;
                    else if (!latch && lo_rel)
                        lo_d = 1'b0;
                end
                // Set beats the reset clear on the same edge
                if (areset && latch) begin
                    if (!(reading_valid[gi] && above))
                        hi_d = 1'b0;
                    if (!(reading_valid[gi] && below))
                        lo_d = 1'b0;
                end
                if (!en) begin
                    hi_d = 1'b0;
                    lo_d = 1'b0;
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    hi_q[gi] <= 1'b0;
                    lo_q[gi] <= 1'b0;
                end else begin
                    hi_q[gi] <= hi_d;
                    lo_q[gi] <= lo_d;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Relays
    // ----------------------------------------------------------------
    logic [1:0] rmode_q  [2];
    logic       rsrc_q   [2];
    logic [1:0] rfol_q   [2];
    logic [1:0] hi_nx;
    logic [1:0] lo_nx;

    // Next alarm state seen by the relays on the same edge
    assign hi_nx = {g_in[1].hi_d, g_in[0].hi_d};
    assign lo_nx = {g_in[1].lo_d, g_in[0].lo_d};

    genvar gr;
    generate
        for (gr = 0; gr < 2; gr++) begin : g_rly
            localparam logic [7:0] ROFF = 8'(OFF_RELAY1 + gr * 4);
            logic coil_d;

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    rmode_q[gr] <= ARL_RLY_OFF;
                    rsrc_q[gr]  <= 1'b0;
                    rfol_q[gr]  <= ARL_FOL_BOTH;
                end else if (wr_pend_q && addr_q == ROFF) begin
                    rmode_q[gr] <= hwdata[RLY_MODE_LO +: 2];
                    rsrc_q[gr]  <= hwdata[RLY_SRC];
                    rfol_q[gr]  <= hwdata[RLY_FOL_LO +: 2];
                end
            end

            always_comb begin
                case (rmode_q[gr])
                    ARL_RLY_OFF:   coil_d = 1'b0;
                    ARL_RLY_ON:    coil_d = 1'b1;
                    ARL_RLY_ALARM: begin
                        case (rfol_q[gr])
                            ARL_FOL_LOW:
                                coil_d = lo_nx[rsrc_q[gr]];
                            ARL_FOL_HIGH:
                                coil_d = hi_nx[rsrc_q[gr]];
                            default:
                                coil_d = lo_nx[rsrc_q[gr]]
                                       | hi_nx[rsrc_q[gr]];
                        endcase
                    end
                    default:       coil_d = 1'b0;
                endcase
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn)
                    relay_coil[gr] <= 1'b0;
                else
                    relay_coil[gr] <= coil_d;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Indicator, beeper and display alternation
    // ----------------------------------------------------------------
    logic [31:0] flash_cnt_q;
    logic        flash_ph_q;
    logic [1:0]  act;
    logic        vis_en, vis_act, aud_act;

    assign act     = hi_q | lo_q;
    assign vis_en  = (ctrl_q[0][CTL_EN] && ctrl_q[0][CTL_VIS])
                   | (ctrl_q[1][CTL_EN] && ctrl_q[1][CTL_VIS]);
    assign vis_act = (act[0] && ctrl_q[0][CTL_VIS])
                   | (act[1] && ctrl_q[1][CTL_VIS]);
    assign aud_act = (act[0] && ctrl_q[0][CTL_AUD])
                   | (act[1] && ctrl_q[1][CTL_AUD]);

    // Free-running divider; phase shared by LED and display
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_cnt_q <= '0;
            flash_ph_q  <= 1'b0;
        end else if (flash_cnt_q == FLASH_LEN - 1) begin
            flash_cnt_q <= '0;
            flash_ph_q  <= !flash_ph_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_led        <= 1'b0;
            beeper           <= 1'b0;
            disp_show_status <= 1'b0;
        end else begin
            if (vis_act)
                alarm_led <= flash_ph_q;
            else
                alarm_led <= vis_en;
            beeper           <= aud_act;
            disp_show_status <= act[display_sel] && flash_ph_q;
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata <= 32'h0000_0000;
            case (haddr[7:0])
                OFF_CTRL_A:  hrdata[3:0]      <= ctrl_q[0];
                OFF_LOW_A:   hrdata[RD_W-1:0] <= low_q[0];
                OFF_HIGH_A:  hrdata[RD_W-1:0] <= high_q[0];
                OFF_DBAND_A: hrdata[RD_W-1:0] <= dband_q[0];
                OFF_CTRL_B:  hrdata[3:0]      <= ctrl_q[1];
                OFF_LOW_B:   hrdata[RD_W-1:0] <= low_q[1];
                OFF_HIGH_B:  hrdata[RD_W-1:0] <= high_q[1];
                OFF_DBAND_B: hrdata[RD_W-1:0] <= dband_q[1];
                OFF_RELAY1:  hrdata[4:0] <= {rfol_q[0], rsrc_q[0],
                                             rmode_q[0]};
                OFF_RELAY2:  hrdata[4:0] <= {rfol_q[1], rsrc_q[1],
                                             rmode_q[1]};
                OFF_STATUS:  hrdata[9:0] <= {relay_coil, 1'b0, beeper,
                                             vis_act, alarm_led,
                                             hi_q[1], lo_q[1],
                                             hi_q[0], lo_q[0]};
                OFF_READ_A:  hrdata[RD_W-1:0] <= rd_q[0];
                OFF_READ_B:  hrdata[RD_W-1:0] <= rd_q[1];
                default:     hrdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : arl_alarm_relay

// file: include/arl_pkg.sv
// Purpose: Shared constants for the alarm and relay block
// Assumes: Readings and setpoints are unsigned fixed point, 1/10000 K LSB
// Notes:   Register map is a private word-aligned layout
package arl_pkg;

    localparam int unsigned DATA_W = 32;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL_A   = 8'h00;
    localparam logic [7:0] OFF_LOW_A    = 8'h04;
    localparam logic [7:0] OFF_HIGH_A   = 8'h08;
    localparam logic [7:0] OFF_DBAND_A  = 8'h0C;
    localparam logic [7:0] OFF_CTRL_B   = 8'h10;
    localparam logic [7:0] OFF_LOW_B    = 8'h14;
    localparam logic [7:0] OFF_HIGH_B   = 8'h18;
    localparam logic [7:0] OFF_DBAND_B  = 8'h1C;
    localparam logic [7:0] OFF_RELAY1   = 8'h20;
    localparam logic [7:0] OFF_RELAY2   = 8'h24;
    localparam logic [7:0] OFF_STATUS   = 8'h28;
    localparam logic [7:0] OFF_ARESET   = 8'h2C;
    localparam logic [7:0] OFF_READ_A   = 8'h30;
    localparam logic [7:0] OFF_READ_B   = 8'h34;
    localparam int unsigned CH_STRIDE   = 16;

    // ----------------------------------------------------------------
    // Input control fields
    // ----------------------------------------------------------------
    localparam int unsigned CTL_EN      = 0;
    localparam int unsigned CTL_VIS     = 1;
    localparam int unsigned CTL_AUD     = 2;
    localparam int unsigned CTL_LATCH   = 3;

    // Relay control fields
    localparam int unsigned RLY_MODE_LO = 0;
    localparam int unsigned RLY_SRC     = 2;
    localparam int unsigned RLY_FOL_LO  = 3;

    // Status fields: per input {high,low} at 2*i, indicator, beeper
    localparam int unsigned ST_IND      = 4;
    localparam int unsigned ST_FLASH    = 5;
    localparam int unsigned ST_BEEP     = 6;
    localparam int unsigned ST_RLY      = 8;

    typedef enum logic [1:0] {
        ARL_RLY_OFF,
        ARL_RLY_ON,
        ARL_RLY_ALARM
    } arl_rly_mode_t;

    typedef enum logic [1:0] {
        ARL_FOL_LOW,
        ARL_FOL_HIGH,
        ARL_FOL_BOTH
    } arl_follow_t;

    // ----------------------------------------------------------------
    // Reset values, 0.1 mK per LSB
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_LOW     = 32'h0000_0000; // 0.0000 K
    localparam logic [31:0] RST_HIGH    = 32'h0098_9680; // 1000 K
    localparam logic [31:0] RST_DBAND   = 32'h0000_2710; // 1.0000 K
    localparam logic [3:0]  RST_CTRL    = 4'h6;          // vis, aud on

    // Flash half period of the indicator and display toggle
    localparam int unsigned CLK_HZ      = 25_000_000;
    localparam int unsigned FLASH_MS    = 500;
    localparam int unsigned FLASH_CYC   = CLK_HZ / 1000 * FLASH_MS;

endpackage : arl_pkg

// file: tb/arl_alarm_relay_assertions.sv
// Purpose: Port checks for the alarm relay block
// Assumes: One hclk domain, async active-low reset
// Notes:   Event ages bound when outputs may move
module arl_alarm_relay_assertions #(
    parameter int unsigned FLASH_LEN = 4
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [1:0]  reading_valid,
    input wire logic [1:0]  relay_coil,
    input wire logic        alarm_led,
    input wire logic        beeper,
    input wire logic        disp_show_status
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        take;
    logic [3:0]  wr_age_q;
    logic [3:0]  rv_age_q;
    logic        any_wr_q;
    int unsigned hi_cnt_q;
    // ------------
    // Event ages
    // ------------
    assign take = hsel && hready && htrans[1];
    // Ages give slack for registered outputs behind config
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_age_q <= 4'hF;
            rv_age_q <= 4'hF;
            any_wr_q <= 1'b0;
            hi_cnt_q <= 0;
        end else begin
            wr_age_q <= (take && hwrite) ? 4'h0 :
                        (wr_age_q == 4'hF) ? 4'hF : wr_age_q + 4'h1;
            rv_age_q <= (reading_valid != 2'b00) ? 4'h0 :
                        (rv_age_q == 4'hF) ? 4'hF : rv_age_q + 4'h1;
            any_wr_q <= any_wr_q || (take && hwrite);
            hi_cnt_q <= disp_show_status ? hi_cnt_q + 1 : 0;
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_ready_always: assert property (hreadyout)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    a_rdata_hold: assert property ($changed(hrdata) |-> $past(take && !hwrite))
        else $error("hrdata moved without read");
    a_unmapped_zero: assert property (take && !hwrite &&
        (haddr == 32'h3C || haddr == 32'h38) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_idle_after_reset: assert property (!any_wr_q |-> relay_coil == 2'b00
        && !alarm_led && !beeper && !disp_show_status)
        else $error("outputs active before config");
    a_coil_cause: assert property ($changed(relay_coil) |->
        rv_age_q <= 4'h1 || wr_age_q <= 4'h4)
        else $error("coil moved without cause");
    a_beep_cause: assert property ($changed(beeper) |->
        rv_age_q <= 4'h2 || wr_age_q <= 4'h5)
        else $error("beeper moved without cause");
    a_status_short: assert property (disp_show_status |->
        hi_cnt_q <= FLASH_LEN)
        else $error("status shown too long");
    c_coil: cover property ($rose(relay_coil[0]));
    c_beep: cover property ($rose(beeper));
    c_flash: cover property ($fell(alarm_led) && beeper);
    c_disp: cover property ($rose(disp_show_status));
endmodule : arl_alarm_relay_assertions

bind arl_alarm_relay arl_alarm_relay_assertions #(.FLASH_LEN(FLASH_LEN)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .reading_valid(reading_valid),
    .relay_coil(relay_coil), .alarm_led(alarm_led), .beeper(beeper),
    .disp_show_status(disp_show_status));

// file: tb/arl_sensor_model.sv
// Purpose: Sensor reading source for the alarm relay bench
// Assumes: Strobes launched just after rising hclk edges
// Notes:   Reading bus shows inverted data outside strobes
module arl_sensor_model #(
    parameter int unsigned RD_W = 32
) (
    input  wire logic            hclk,
    output logic      [RD_W-1:0] reading_a,
    output logic      [RD_W-1:0] reading_b,
    output logic      [1:0]      reading_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reading_a     = '0;
        reading_b     = '0;
        reading_valid = 2'b00;
    end
    // Inverted off-strobe so a stale value cannot pass
    task automatic send(input logic ch, input logic [RD_W-1:0] v);
        @(posedge hclk);
        reading_a     <= ch ? reading_a : v;
        reading_b     <= ch ? v : reading_b;
        reading_valid <= ch ? 2'b10 : 2'b01;
        @(posedge hclk);
        reading_valid <= 2'b00;
        reading_a     <= ~reading_a;
        reading_b     <= ~reading_b;
    endtask : send
endmodule : arl_sensor_model

// file: tb/tb.sv
// Purpose: Self-checking bench for the alarm relay block
// Assumes: Zero-wait slave, flash half period cut to 4
// Notes:   Expected values come from the alarm rules only
module tb
    import arl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned FL = 4;
    logic        hclk, hresetn, hsel, hwrite, display_sel;
    logic        hreadyout, hresp, alarm_led, beeper, disp_show_status;
    logic [31:0] haddr, hwdata, hrdata, reading_a, reading_b;
    logic [1:0]  htrans, reading_valid, relay_coil;
    logic [2:0]  hsize;
    int          num_errors = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    arl_alarm_relay #(.RD_W(32), .FLASH_LEN(FL)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .reading_a(reading_a), .reading_b(reading_b),
        .reading_valid(reading_valid), .display_sel(display_sel),
        .relay_coil(relay_coil), .alarm_led(alarm_led), .beeper(beeper),
        .disp_show_status(disp_show_status));
    arl_sensor_model #(.RD_W(32)) u_src (.hclk(hclk), .reading_a(reading_a),
        .reading_b(reading_b), .reading_valid(reading_valid));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // ------------
    // Bus and compare
    // ------------
    task automatic check(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] off,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, off};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] off, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, off, d, r);
    endtask : wr
    task automatic rc(input string n, input logic [7:0] off,
                      input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, off, 32'h0, r);
        check(n, e, r);
    endtask : rc
    task automatic feed(input logic ch, input logic [31:0] v,
                        input logic [3:0] fl, input logic [1:0] co);
        logic [31:0] r;
        u_src.send(ch, v);
        #1;
        check("relay_coil", {30'h0, co}, {30'h0, relay_coil});
        bus(1'b0, OFF_STATUS, 32'h0, r);
        check("status", {26'h0, co, fl}, {26'h0, r[9:8], r[3:0]});
    endtask : feed
    // Relay config lands at the write's data edge, the coil one edge on;
    // a fixed wait stops a stale coil level from passing
    task automatic coil_is(input logic [1:0] co);
        @(posedge hclk);
        #1;
        check("relay_coil", {30'h0, co}, {30'h0, relay_coil});
    endtask : coil_is
    task automatic end_of_test;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    // ------------
    // Scenarios
    // ------------
    task automatic s_reset;
        logic [7:0]  o [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                                8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h3C};
        logic [31:0] v [12] = '{32'h6, 32'h0, 32'h0098_9680, 32'h2710,
                                32'h6, 32'h0, 32'h0098_9680, 32'h2710,
                                32'h10, 32'h10, 32'h0, 32'h0};
        wr(8'h3C, 32'hFFFF_FFFF);
        foreach (o[i]) rc("reset_value", o[i], v[i]);
    endtask : s_reset
    task automatic s_levels;
        wr(OFF_RELAY1, 32'h12);
        feed(1'b0, 32'hFFFF_FFFF, 4'h0, 2'b00);
        wr(OFF_HIGH_A, 32'h000F_4240);
        wr(OFF_DBAND_A, 32'h0000_C350);
        wr(OFF_CTRL_A, 32'h1);
        wr(OFF_RELAY1, 32'h0A);
        wr(OFF_RELAY2, 32'h02);
        feed(1'b0, 32'h000F_4240, 4'h0, 2'b00);
        feed(1'b0, 32'h000F_4241, 4'h2, 2'b01);
        feed(1'b0, 32'h000E_7EF1, 4'h2, 2'b01);
        feed(1'b0, 32'h000E_7EF0, 4'h0, 2'b00);
        wr(OFF_LOW_A, 32'h0001_86A0);
        feed(1'b0, 32'h0001_869F, 4'h1, 2'b10);
        feed(1'b0, 32'h0002_49EF, 4'h1, 2'b10);
        feed(1'b0, 32'h0002_49F0, 4'h0, 2'b00);
    endtask : s_levels
    task automatic s_modes;
        logic [7:0] c [7] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h0E, 8'h16, 8'h12};
        logic       e [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        wr(OFF_CTRL_B, 32'h1);
        feed(1'b1, 32'h0098_9681, 4'h8, 2'b00);
        foreach (c[i]) begin
            wr(OFF_RELAY1, {24'h0, c[i]});
            coil_is({1'b0, e[i]});
        end
        wr(OFF_CTRL_B, 32'h0);
        rc("status", OFF_STATUS, 32'h0);
    endtask : s_modes
    task automatic s_latch;
        wr(OFF_CTRL_A, 32'h9);
        feed(1'b0, 32'h000F_4241, 4'h2, 2'b01);
        feed(1'b0, 32'h0007_A120, 4'h2, 2'b01);
        wr(OFF_ARESET, 32'h1);
        coil_is(2'b00);
        rc("status", OFF_STATUS, 32'h0);
    endtask : s_latch
    task automatic s_annun;
        int n_led;
        int n_disp;
        n_led = 0;
        n_disp = 0;
        wr(OFF_CTRL_A, 32'h7);
        display_sel <= 1'b0;
        feed(1'b0, 32'h000F_4241, 4'h2, 2'b01);
        repeat (2 * FL + 4) begin
            @(posedge hclk);
            #1;
            n_led += alarm_led;
            n_disp += disp_show_status;
        end
        check("led_flash", 32'h1, {31'h0, n_led > 0 && n_led < 12});
        check("disp_alt", 32'h1, {31'h0, n_disp > 0 && n_disp < 12});
        check("beeper", 32'h1, {31'h0, beeper});
        @(posedge hclk);
        display_sel <= 1'b1;
        n_disp = 0;
        repeat (2 * FL + 4) begin
            @(posedge hclk);
            #1;
            n_disp += disp_show_status;
        end
        check("disp_other", 32'h0, n_disp);
        feed(1'b0, 32'h0007_A120, 4'h0, 2'b00);
        check("led_steady", 32'h1, {31'h0, alarm_led});
        check("beeper", 32'h0, {31'h0, beeper});
        wr(OFF_CTRL_A, 32'h1);
        rc("status", OFF_STATUS, 32'h0);
        check("led_off", 32'h0, {31'h0, alarm_led});
    endtask : s_annun
    // ------------
    // Main sequence
    // ------------
    initial begin
        hresetn     = 1'b0;
        hsel        = 1'b0;
        haddr       = 32'h0;
        htrans      = 2'b00;
        hwrite      = 1'b0;
        hsize       = 3'h2;
        hwdata      = 32'h0;
        display_sel = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        s_reset();
        s_levels();
        s_modes();
        s_latch();
        s_annun();
        end_of_test();
    end
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end
endmodule : tb
